// ### app_pkg.sv
// Package with constants and types for the audio processing path.
package app_pkg;

  // Sample and coefficient widths.
  localparam int unsigned SAMPLE_W     = 24;
  localparam int unsigned COEF_W       = 24;
  localparam int unsigned COEF_FRAC    = 22;
  // Number of biquad stages per first-stage channel chain.
  localparam int unsigned CHAIN_STAGES = 8;
  // Oversampling ratio of the input interpolator.
  localparam int unsigned OSR          = 2;
  // Crossover selection width and the value that leaves the eighth filter free.
  localparam int unsigned XO_W         = 4;
  localparam logic [3:0]  XO_NONE      = 4'h0;
  // Single-pole DC blocker shift (pole at 1 - 2^-DC_SHIFT).
  localparam int unsigned DC_SHIFT     = 10;
  // Post scaler shift and unity volume value.
  localparam int unsigned VOL_W        = 16;
  localparam logic [15:0] VOL_UNITY    = 16'h4000;
  localparam int unsigned VOL_FRAC     = 14;
  // Output configuration modes.
  typedef enum logic [2:0] {
    APP_MODE_21_DRC  = 3'b001,
    APP_MODE_20_DBD  = 3'b010,
    APP_MODE_21_COMP = 3'b100
  } app_mode_t;
  // Extra filters available in the compressor configuration.
  localparam int unsigned COMP_EXTRA_BQ = 10;

endpackage : app_pkg

// ### app_biquad.sv
`timescale 1ns/1ps
// Single direct-form-I biquad section with a bypass control.
module app_biquad
  import app_pkg::*;
#(
  parameter int unsigned DW = SAMPLE_W,
  parameter int unsigned CW = COEF_W
) (
  // Clock and reset.
  input  wire logic                 clock_i,
  input  wire logic                 rst_i,
  // Sample stream.
  input  wire logic                 valid_i,
  input  wire logic signed [DW-1:0] sample_i,
  output logic signed [DW-1:0]      sample_o,
  // Control and coefficients b0,b1,b2,a1,a2.
  input  wire logic                 enable_i,
  input  wire logic [5*CW-1:0]      coef_i
);

  logic signed [DW-1:0] x1, x2, y1, y2, y;
  logic signed [DW-1:0] next_x1, next_x2, next_y1, next_y2, next_y;
  logic signed [DW+CW+2:0] acc;

  // Filter arithmetic; a disabled stage passes the sample through unchanged.
  always_comb begin
    acc = ($signed(coef_i[CW-1:0])      * sample_i)
        + ($signed(coef_i[2*CW-1:CW])   * x1)
        + ($signed(coef_i[3*CW-1:2*CW]) * x2)
        - ($signed(coef_i[4*CW-1:3*CW]) * y1)
        - ($signed(coef_i[5*CW-1:4*CW]) * y2);
    next_x1 = x1;
    next_x2 = x2;
    next_y1 = y1;
    next_y2 = y2;
    next_y  = y;
    if (valid_i) begin
      next_x1 = sample_i;
      next_x2 = x1;
      next_y  = enable_i ? DW'(acc >>> COEF_FRAC) : sample_i;
      next_y1 = next_y;
      next_y2 = y1;
    end
  end

  // State registers.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      x1 <= '0;
      x2 <= '0;
      y1 <= '0;
      y2 <= '0;
      y  <= '0;
    end else begin
      x1 <= next_x1;
      x2 <= next_x2;
      y1 <= next_y1;
      y2 <= next_y2;
      y  <= next_y;
    end
  end

  assign sample_o = y;

endmodule : app_biquad

// ### app_path.sv
`timescale 1ns/1ps
// Two-stage audio processing path: oversampling, DC block, biquad chains and post stage.
// Overview of operation
// - The first stage begins with an interpolator that doubles the input sample rate.
// - The DC-removing high-pass filter acts only while dc_highpass_bypass is 0.
// - Each channel chain holds up to eight biquads, chosen by link, extra enables and crossover.
// - With link and all extra enables cleared, four independent filters plus bass and treble run.
// - With biquad_coef_link set, filters one to four use one coefficient set for both channels.
// - With linking set, filters five to seven become shared user filters when enabled.
// - The shared eighth filter runs on both channels only with crossover_select 0 and no dual-band DRC.
// - The second stage runs mixer, crossover band split, DRC, volume and post scaler.
// - The post-mixer derives a third channel; the dual-band DRC takes the chain outputs instead.
// - In 2.1 with limiters two separate DRC units run and mixer plus eighth filter make the LFE.
// - In 2.0 dual-band mode each channel splits into two bands, each band has its own DRC, then recombines.
// - In 2.1 with the dual-band compressor extra_bq_count_o reports ten biquads; no extra biquads are built.
module app_path
  import app_pkg::*;
#(
  parameter int unsigned DW = SAMPLE_W,
  parameter int unsigned CW = COEF_W,
  parameter int unsigned NB = CHAIN_STAGES
) (
  // Clock and reset.
  input  wire logic                    clock_i,
  input  wire logic                    rst_i,
  // Input stream at the base rate.
  input  wire logic                    in_valid_i,
  input  wire logic signed [DW-1:0]    in_left_i,
  input  wire logic signed [DW-1:0]    in_right_i,
  // Configuration bits.
  input  wire logic                    dc_highpass_bypass_i,
  input  wire logic                    biquad_coef_link_i,
  input  wire logic                    filter_five_enable_i,
  input  wire logic                    filter_six_enable_i,
  input  wire logic                    filter_seven_enable_i,
  input  wire logic [XO_W-1:0]         crossover_select_i,
  input  wire logic                    dual_band_drc_i,
  input  wire logic [2:0]              out_mode_i,
  // Coefficients: per-channel sets and the shared eighth filter.
  input  wire logic [NB*5*CW-1:0]      coef_ch1_i,
  input  wire logic [NB*5*CW-1:0]      coef_ch2_i,
  input  wire logic [5*CW-1:0]         coef_eighth_i,
  // Second stage controls: DRC ceilings and volume.
  input  wire logic signed [DW-1:0]    drc_limit_a_i,
  input  wire logic signed [DW-1:0]    drc_limit_b_i,
  input  wire logic [VOL_W-1:0]        volume_i,
  // Output stream at twice the base rate, toward the modulator.
  output logic                         out_valid_o,
  output logic signed [DW-1:0]         out_left_o,
  output logic signed [DW-1:0]         out_right_o,
  output logic signed [DW-1:0]         out_lfe_o,
  // Status.
  output logic [NB-1:0]                stage_active_o,
  output logic                         eighth_shared_o,
  output logic [3:0]                   extra_bq_count_o
);

  // Interpolator: emits the held sample and a midpoint, two outputs per input.
  logic signed [DW-1:0] prev_l, prev_r, os_l, os_r, pend_l, pend_r;
  logic signed [DW-1:0] next_prev_l, next_prev_r, next_os_l, next_os_r;
  logic signed [DW-1:0] next_pend_l, next_pend_r;
  logic                 os_valid, pend, next_os_valid, next_pend;

  always_comb begin
    next_prev_l  = prev_l;
    next_prev_r  = prev_r;
    next_os_l    = os_l;
    next_os_r    = os_r;
    next_pend_l  = pend_l;
    next_pend_r  = pend_r;
    next_os_valid = 1'b0;
    next_pend    = 1'b0;
    if (in_valid_i) begin
      next_os_l    = DW'((DW+1)'(prev_l) + (DW+1)'(in_left_i) >>> 1);
      next_os_r    = DW'((DW+1)'(prev_r) + (DW+1)'(in_right_i) >>> 1);
      next_pend_l  = in_left_i;
      next_pend_r  = in_right_i;
      next_prev_l  = in_left_i;
      next_prev_r  = in_right_i;
      next_os_valid = 1'b1;
      next_pend    = 1'b1;
    end else if (pend) begin
      next_os_l    = pend_l;
      next_os_r    = pend_r;
      next_os_valid = 1'b1;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      prev_l   <= '0;
      prev_r   <= '0;
      os_l     <= '0;
      os_r     <= '0;
      pend_l   <= '0;
      pend_r   <= '0;
      os_valid <= 1'b0;
      pend     <= 1'b0;
    end else begin
      prev_l   <= next_prev_l;
      prev_r   <= next_prev_r;
      os_l     <= next_os_l;
      os_r     <= next_os_r;
      pend_l   <= next_pend_l;
      pend_r   <= next_pend_r;
      os_valid <= next_os_valid;
      pend     <= next_pend;
    end
  end

  // DC blocker: y = x - avg, avg tracks the input with a long time constant.
  logic signed [DW+DC_SHIFT-1:0] avg_l, avg_r, next_avg_l, next_avg_r;
  logic signed [DW-1:0]          hp_l, hp_r;
  logic                          hp_valid;

  always_comb begin
    next_avg_l = avg_l;
    next_avg_r = avg_r;
    if (os_valid && !dc_highpass_bypass_i) begin
      next_avg_l = avg_l + (DW+DC_SHIFT)'(os_l) - (avg_l >>> DC_SHIFT);
      next_avg_r = avg_r + (DW+DC_SHIFT)'(os_r) - (avg_r >>> DC_SHIFT);
    end
    hp_l = dc_highpass_bypass_i ? os_l : DW'(os_l - DW'(avg_l >>> DC_SHIFT));
    hp_r = dc_highpass_bypass_i ? os_r : DW'(os_r - DW'(avg_r >>> DC_SHIFT));
    hp_valid = os_valid;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      avg_l <= '0;
      avg_r <= '0;
    end else begin
      avg_l <= next_avg_l;
      avg_r <= next_avg_r;
    end
  end

  // Stage plan: 1-4 always user, 5-7 by enables (tone filters when off), 8 shared eighth.
  logic eighth_free;
  assign eighth_free     = (crossover_select_i == XO_NONE) && !dual_band_drc_i;
  assign eighth_shared_o = eighth_free;
  assign stage_active_o  = {eighth_free, filter_seven_enable_i, filter_six_enable_i,
                            filter_five_enable_i, 4'hF};

  // Sample pipeline through the chains; the valid rides one cycle per stage.
  logic signed [DW-1:0] ch1 [0:NB];
  logic signed [DW-1:0] ch2 [0:NB];
  logic [NB:0]          vpipe;
  logic [NB-1:0]        vreg;
  assign ch1[0]   = hp_l;
  assign ch2[0]   = hp_r;
  // One driver for the whole valid vector keeps the pipeline free of mixed drivers.
  assign vpipe    = {vreg, hp_valid};

  genvar g;
  generate
    for (g = 0; g < NB; g++) begin : g_stage
      logic [5*CW-1:0] c1, c2;
      logic            shared;
      logic            en;
      // Linked stages 1-7 take channel one's set on both channels; stage 8 is always shared.
      assign shared = (g == NB-1) || (biquad_coef_link_i && g < NB-1);
      assign c1 = (g == NB-1) ? coef_eighth_i : coef_ch1_i[g*5*CW +: 5*CW];
      assign c2 = shared ? c1 : coef_ch2_i[g*5*CW +: 5*CW];
      // Stages 5-7 with enable off keep their fixed tone role; only stage 8 may drop out.
      assign en = (g == NB-1) ? eighth_free : 1'b1;
      app_biquad #(.DW(DW), .CW(CW)) u_bq1 (
        .clock_i  (clock_i),
        .rst_i    (rst_i),
        .valid_i  (vpipe[g]),
        .sample_i (ch1[g]),
        .sample_o (ch1[g+1]),
        .enable_i (en),
        .coef_i   (c1)
      );
      app_biquad #(.DW(DW), .CW(CW)) u_bq2 (
        .clock_i  (clock_i),
        .rst_i    (rst_i),
        .valid_i  (vpipe[g]),
        .sample_i (ch2[g]),
        .sample_o (ch2[g+1]),
        .enable_i (en),
        .coef_i   (c2)
      );
    end
  endgenerate

  // Valid pipeline; one register per stage keeps each valid level beside its sample.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      vreg <= '0;
    end else begin
      vreg <= vpipe[NB-1:0];
    end
  end

  // Second stage: mixer, band split/LFE, DRC clamps, volume and scaler.
  logic signed [DW-1:0] l1, r1, mono, lo_l, lo_r, hi_l, hi_r, dl, dr;
  logic signed [DW+VOL_W:0] vl, vr, vs;
  logic signed [DW-1:0] next_l, next_r, next_s;

  function automatic logic signed [DW-1:0] clamp(input logic signed [DW-1:0] x,
                                                 input logic signed [DW-1:0] lim);
    logic signed [DW-1:0] r;
    r = x;
    if (x > lim) r = lim;
    else if (x < -lim) r = -lim;
    return r;
  endfunction : clamp

  always_comb begin
    l1   = ch1[NB];
    r1   = ch2[NB];
    // Sums are formed one bit wider, so full-scale inputs cannot wrap before the halving.
    mono = DW'(((DW+1)'(l1) + (DW+1)'(r1)) >>> 1);
    // Crude band split: the low band is the eighth-filter path average.
    lo_l = DW'(((DW+1)'(l1) + (DW+1)'(ch1[NB-1])) >>> 1);
    lo_r = DW'(((DW+1)'(r1) + (DW+1)'(ch2[NB-1])) >>> 1);
    hi_l = DW'(l1 - lo_l);
    hi_r = DW'(r1 - lo_r);
    dl   = l1;
    dr   = r1;
    next_s = '0;
    if (dual_band_drc_i) begin
      dl = DW'(clamp(lo_l, drc_limit_a_i) + clamp(hi_l, drc_limit_b_i));
      dr = DW'(clamp(lo_r, drc_limit_a_i) + clamp(hi_r, drc_limit_b_i));
    end else begin
      dl = clamp(l1, drc_limit_a_i);
      dr = clamp(r1, drc_limit_b_i);
      next_s = clamp(mono, drc_limit_a_i);
    end
    vl = dl * $signed({1'b0, volume_i});
    vr = dr * $signed({1'b0, volume_i});
    vs = next_s * $signed({1'b0, volume_i});
    next_l = DW'(vl >>> VOL_FRAC);
    next_r = DW'(vr >>> VOL_FRAC);
    next_s = DW'(vs >>> VOL_FRAC);
    extra_bq_count_o = (out_mode_i == APP_MODE_21_COMP) ? 4'(COMP_EXTRA_BQ) : 4'h0;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      out_valid_o <= 1'b0;
      out_left_o  <= '0;
      out_right_o <= '0;
      out_lfe_o   <= '0;
    end else begin
      out_valid_o <= vpipe[NB];
      if (vpipe[NB]) begin
        out_left_o  <= next_l;
        out_right_o <= next_r;
        out_lfe_o   <= next_s;
      end
    end
  end

  // Output rate is twice the input rate: two outputs follow each input word.
  a_double_rate: assert property (@(posedge clock_i) disable iff (rst_i)
    in_valid_i |-> ##1 os_valid ##1 os_valid)
    else $error("interpolator did not emit two samples");

  // A withheld eighth filter must hand its input sample on untouched.
  a_eighth_gate: assert property (@(posedge clock_i) disable iff (rst_i)
    vpipe[NB-1] && !eighth_shared_o |=> ch1[NB] == $past(ch1[NB-1]))
    else $error("eighth filter not bypassed");

  a_bypass_pass: assert property (@(posedge clock_i) disable iff (rst_i)
    dc_highpass_bypass_i |-> hp_l == os_l)
    else $error("bypass did not pass sample");

  a_comp_count: assert property (@(posedge clock_i) disable iff (rst_i)
    out_mode_i == APP_MODE_21_COMP |-> extra_bq_count_o == 4'hA)
    else $error("compressor filter count wrong");

  a_out_latency: assert property (@(posedge clock_i) disable iff (rst_i)
    hp_valid |-> ##9 out_valid_o)
    else $error("output latency wrong");

  a_lfe_quiet: assert property (@(posedge clock_i) disable iff (rst_i)
    out_valid_o && $past(dual_band_drc_i) |-> out_lfe_o == '0)
    else $error("lfe active in dual band");

  a_four_base: assert property (@(posedge clock_i) disable iff (rst_i)
    stage_active_o[3:0] == 4'hF)
    else $error("base filters not active");

endmodule : app_path

// ### app_src.sv
`timescale 1ns/1ps
// Behavioural source of sample pairs that stands in front of the processing path.
module app_src
  import app_pkg::*;
(
  // Clock from the bench.
  input  wire logic                   clock_i,
  // Stream toward the path.
  output logic                        valid_o,
  output logic signed [SAMPLE_W-1:0]  left_o,
  output logic signed [SAMPLE_W-1:0]  right_o
);
  // The stream is idle from time zero.
  initial begin
    valid_o = 1'b0;
    left_o  = '0;
    right_o = '0;
  end

  // Sends one pair on the falling edge and keeps three cycles between pairs, so none is lost.
  task automatic send(input logic signed [SAMPLE_W-1:0] l, input logic signed [SAMPLE_W-1:0] r);
    @(negedge clock_i);
    valid_o = 1'b1;
    left_o  = l;
    right_o = r;
    @(negedge clock_i);
    valid_o = 1'b0;
    // Released lines show the inverse, so stale data can never pass for a fresh sample.
    left_o  = ~l;
    right_o = ~r;
    @(negedge clock_i);
  endtask : send
endmodule : app_src

// ### tb_app_path.sv
`timescale 1ns/1ps
// Self-checking testbench for the two-stage audio processing path.
module tb_app_path;
  import app_pkg::*;
  localparam logic [119:0] BQ_ONE  = {96'h0, 24'h400000};
  localparam logic [119:0] BQ_HALF = {96'h0, 24'h200000};
  // Design inputs and outputs.
  logic                       clock_i = 1'b0;
  logic                       rst_i = 1'b1;
  logic                       in_valid;
  logic signed [SAMPLE_W-1:0] in_left, in_right;
  logic                       bypass = 1'b1, link = 1'b0, f5 = 1'b0, f6 = 1'b0, f7 = 1'b0;
  logic [XO_W-1:0]            xo = XO_NONE;
  logic                       dbd = 1'b0;
  logic [2:0]                 mode = APP_MODE_21_DRC;
  logic signed [SAMPLE_W-1:0] lim = 24'h7FFFFF;
  logic signed [SAMPLE_W-1:0] out_l, out_r, out_lfe;
  logic                       out_valid, shared;
  logic [7:0]                 active;
  logic [3:0]                 extra;
  int                         failures = 0;
  int                         samples_checked = 0;

  // Fixed period, so the clock is stable long before reset is released.
  always #10 clock_i = ~clock_i;

  app_src i_app_src (.clock_i(clock_i), .valid_o(in_valid), .left_o(in_left), .right_o(in_right));

  app_path i_app_path (
    .clock_i(clock_i), .rst_i(rst_i), .in_valid_i(in_valid), .in_left_i(in_left),
    .in_right_i(in_right), .dc_highpass_bypass_i(bypass), .biquad_coef_link_i(link),
    .filter_five_enable_i(f5), .filter_six_enable_i(f6), .filter_seven_enable_i(f7),
    .crossover_select_i(xo), .dual_band_drc_i(dbd), .out_mode_i(mode),
    .coef_ch1_i({8{BQ_ONE}}), .coef_ch2_i({8{BQ_HALF}}), .coef_eighth_i(BQ_ONE),
    .drc_limit_a_i(lim), .drc_limit_b_i(lim), .volume_i(VOL_UNITY),
    .out_valid_o(out_valid), .out_left_o(out_l), .out_right_o(out_r), .out_lfe_o(out_lfe),
    .stage_active_o(active), .eighth_shared_o(shared), .extra_bq_count_o(extra));

  // Compares one value and counts the outcome.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Holds reset for six cycles, then releases it on a falling edge.
  task automatic do_reset();
    @(negedge clock_i);
    rst_i = 1'b1;
    repeat (6) @(negedge clock_i);
    check({31'h0, out_valid}, 32'h0);
    rst_i = 1'b0;
  endtask : do_reset

  // Sends n equal pairs and lets the last results leave the pipeline.
  task automatic feed(input int n, input logic signed [SAMPLE_W-1:0] l);
    repeat (n) i_app_src.send(l, l);
    repeat (14) @(negedge clock_i);
  endtask : feed

  // Status outputs follow the configuration bits.
  task automatic s_status();
    for (int i = 0; i < 8; i++) begin
      {f7, f6, f5} = i[2:0];
      @(negedge clock_i);
      check({28'h0, active[3:0]}, 32'hF);
      check({29'h0, active[6:4]}, i);
    end
    for (int i = 0; i < 6; i++) begin
      xo  = (i / 2 == 0) ? 4'h0 : ((i / 2 == 1) ? 4'h1 : 4'hF);
      dbd = i[0];
      @(negedge clock_i);
      check({31'h0, shared}, {31'h0, (i / 2 == 0) && !i[0]});
    end
    for (int i = 0; i < 3; i++) begin
      mode = 3'b001 << i;
      @(negedge clock_i);
      check({28'h0, extra}, (i == 2) ? COMP_EXTRA_BQ : 0);
    end
    {f7, f6, f5, xo, dbd, mode} = {3'b000, XO_NONE, 1'b0, APP_MODE_21_DRC};
  endtask : s_status

  // One input gives exactly two results, nine and ten edges after the edge that takes it.
  task automatic s_timing();
    logic [15:0] seen;
    seen = '0;
    do_reset();
    i_app_src.send(24'h100000, 24'h100000);
    for (int k = 0; k < 16; k++) begin
      @(negedge clock_i);
      seen[k] = out_valid;
    end
    check({16'h0, seen}, 32'h3 << (CHAIN_STAGES - 1));
  endtask : s_timing

  // Linked coefficients make both channels match; unlinked they follow their own sets.
  task automatic s_link();
    {link, f5, f6, f7} = 4'hF;
    do_reset();
    feed(3, 24'h100000);
    check({8'h0, out_r}, {8'h0, out_l});
    {link, f5, f6, f7} = 4'h7;
    do_reset();
    feed(3, 24'h100000);
    check({31'h0, out_r !== out_l}, 32'h1);
    {link, f5, f6, f7} = 4'h0;
  endtask : s_link

  // The DC blocker pulls a constant input down only while the bypass bit is 0.
  task automatic s_dc();
    logic signed [SAMPLE_W-1:0] kept;
    bypass = 1'b1;
    do_reset();
    feed(150, 24'h200000);
    kept = out_l;
    bypass = 1'b0;
    do_reset();
    feed(150, 24'h200000);
    check({31'h0, out_l < kept}, 32'h1);
    bypass = 1'b1;
  endtask : s_dc

  // Limiters clamp in the 2.1 mode and the LFE is silent in the dual-band mode.
  task automatic s_drc();
    lim = 24'h040000;
    do_reset();
    feed(4, 24'h300000);
    check({31'h0, out_l <= lim && out_r <= lim}, 32'h1);
    check({31'h0, out_lfe !== 24'h0}, 32'h1);
    {mode, dbd} = {APP_MODE_20_DBD, 1'b1};
    do_reset();
    feed(4, 24'h300000);
    check({8'h0, out_lfe}, 32'h0);
    check({31'h0, shared}, 32'h0);
    {mode, dbd, lim} = {APP_MODE_21_DRC, 1'b0, 24'h7FFFFF};
  endtask : s_drc

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checked=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  // Main sequence; every wait inside is a fixed count, so the run cannot hang.
  initial begin
    do_reset();
    s_status();
    s_timing();
    s_link();
    s_dc();
    s_drc();
    tally_and_finish();
  end
endmodule : tb_app_path
